// ==== rtl/pvl_pkg.sv ====
// Shared constants for the vendor indicator and event register bank
package pvl_pkg;
  // Register indices on the management link
  localparam logic [4:0] PVL_IDX_LINK_HEALTH = 5'h13; // link_speed_health
  localparam logic [4:0] PVL_IDX_RXERR_TALLY = 5'h15; // receive_error_tally
  localparam logic [4:0] PVL_IDX_IND_SELECT  = 5'h16; // indicator_function_select
  localparam logic [4:0] PVL_IDX_IND_BEHAV   = 5'h17; // indicator_behaviour
  localparam logic [4:0] PVL_IDX_OUT_DRIVE   = 5'h19; // mgmt_output_drive
  localparam logic [4:0] PVL_IDX_IND_SCHEME  = 5'h1A; // indicator_scheme
  localparam logic [4:0] PVL_IDX_EVENT       = 5'h1B; // event_enable_and_flags
  localparam logic [4:0] PVL_IDX_CONTROL     = 5'h1F; // Control, polarity bit only

  // Field positions
  localparam int PVL_POS_LINK_100    = 0;
  localparam int PVL_POS_LINK_1000   = 1;
  localparam int PVL_POS_SEL_SECOND  = 4;  // 7:4
  localparam int PVL_POS_SEL_FIRST   = 0;  // 3:0
  localparam int PVL_POS_ACT_SELECT  = 14;
  localparam int PVL_POS_PULSE_EN    = 12;
  localparam int PVL_POS_RATE        = 10; // 11:10
  localparam int PVL_POS_STRETCH_EN  = 5;  // 6:5
  localparam int PVL_POS_COMB_DIS    = 0;  // 1:0
  localparam int PVL_POS_PUSH_PULL   = 1;
  localparam int PVL_POS_LEGACY      = 14;
  localparam int PVL_POS_EVENT_EN    = 8;  // 15:8
  localparam int PVL_POS_EVENT_FLAG  = 0;  // 7:0
  localparam int PVL_POS_IRQ_INVERT  = 14;

  // Reset values
  localparam logic [3:0]  PVL_RST_SEL_SECOND = 4'h2;
  localparam logic [3:0]  PVL_RST_SEL_FIRST  = 4'h1;
  localparam logic        PVL_RST_ACT_SELECT = 1'b0;
  localparam logic        PVL_RST_PULSE_EN   = 1'b1;
  localparam logic [1:0]  PVL_RST_RATE       = 2'h0;
  localparam logic [1:0]  PVL_RST_STRETCH_EN = 2'h0;
  localparam logic [1:0]  PVL_RST_COMB_DIS   = 2'h0;
  localparam logic        PVL_RST_PUSH_PULL  = 1'b0;
  localparam logic        PVL_RST_LEGACY     = 1'b1;
  localparam logic [7:0]  PVL_RST_EVENT_EN   = 8'h00;
  localparam logic [7:0]  PVL_RST_EVENT_FLAG = 8'h00;
  localparam logic        PVL_RST_IRQ_INVERT = 1'b0;
  localparam logic [15:0] PVL_RST_TALLY      = 16'h0000;
  localparam logic [15:0] PVL_TALLY_MAX      = 16'hFFFF;

  // Timing: one base tick is 25 ms; blink half-periods and stretches are tick multiples
  localparam int PVL_CLK_HZ      = 20_000_000;
  localparam int PVL_TICK_MS     = 25;
  localparam int PVL_TICK_CYCLES = PVL_CLK_HZ / 1000 * PVL_TICK_MS;
  localparam logic [4:0] PVL_STRETCH_TICKS_SLOW = 5'h10; // 400 ms at rate 00
endpackage

// ==== rtl/pvl_ind_if.sv ====
// Indicator configuration carried from the register bank to the timing engine
`timescale 1ns/1ps
`default_nettype none
interface pvl_ind_if;
  logic       extended;   // Extended scheme active
  logic [1:0] rate;       // Blink / stretch rate code
  logic [1:0] stretch_en; // Per indicator: stretch when 1, blink when 0
  logic [1:0] comb_dis;   // Per indicator: no activity combination when 1
  logic       tick;       // 25 ms enable pulse from the divider

  // Register bank drives the settings
  modport bank (output extended, output rate, output stretch_en, output comb_dis,
                input tick);
  // Timing engine consumes them
  modport timing (input extended, input rate, input stretch_en, input comb_dis,
                  output tick);
endinterface
`default_nettype wire

// ==== rtl/pvl_ind_timing.sv ====
// Blink and pulse-stretch engine for the two indicator outputs
`timescale 1ns/1ps
`default_nettype none
module pvl_ind_timing
  import pvl_pkg::*;
#(
  parameter int TICK_CYC = PVL_TICK_CYCLES
) (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic [1:0] base_lvl,
  input  wire logic [1:0] act_evt,
  pvl_ind_if.timing       cfg,
  output logic [1:0]      ind_out
);
  logic [22:0] div_reg;   // Reference clock divider
  logic [3:0]  phase_reg; // Blink phase in ticks
  logic        blink_on;  // Current blink phase bit
  logic [4:0]  load_val;  // Stretch length in ticks for the rate

  // Divide the reference clock into a 25 ms tick
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      div_reg <= '0;
    end else if (div_reg == 23'(TICK_CYC - 1)) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 23'd1;
    end
  end
  assign cfg.tick = (div_reg == 23'(TICK_CYC - 1)); // [R17]

  // Blink phase: half period is 8, 4, 2 or 1 ticks
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      phase_reg <= '0;
    end else if (cfg.tick) begin
      phase_reg <= phase_reg + 4'd1;
    end
  end
  assign blink_on = phase_reg[2'd3 - cfg.rate];            // [R8]
  assign load_val = PVL_STRETCH_TICKS_SLOW >> cfg.rate;    // [R8]

  // One stretch counter and output stage per indicator
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_ind
      logic [4:0] str_reg; // Remaining stretch ticks
      logic       act_vis; // Activity as shown
      logic       stretch;
      assign stretch = cfg.extended & cfg.stretch_en[i]; // [R5] [R9]
      always_ff @(posedge core_clk) begin
        if (!nrst) begin
          str_reg <= '0;
        end else if (act_evt[i]) begin
          str_reg <= load_val;
        end else if (cfg.tick && str_reg != 5'd0) begin
          str_reg <= str_reg - 5'd1;
        end
      end
      assign act_vis = stretch ? (str_reg != 5'd0) : (act_evt[i] & blink_on); // [R9]
      // Combined: base light goes dark while activity is shown
      always_ff @(posedge core_clk) begin
        if (!nrst) begin
          ind_out[i] <= 1'b0;
        end else if (cfg.extended && cfg.comb_dis[i]) begin
          ind_out[i] <= base_lvl[i];                        // [R10]
        end else begin
          ind_out[i] <= base_lvl[i] & ~act_vis;             // [R10]
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ==== rtl/pvl_regs.sv ====
// Vendor register bank: link health, error tally, indicators, drive, events
// How it works
// [R1] Read-only gigabit and 100M link-good bits
// [R2] Saturating receive error tally, cleared on read
// [R3] Second indicator function field, bits 7:4
// [R4] First indicator function field, bits 3:0
// [R5] Select and behaviour only act in extended scheme
// [R6] Bit 14 picks legacy (1) or extended scheme
// [R7] Controller should keep writing legacy bit as 1
// [R8] Rate code sets blink and stretch timing
// [R9] Stretch enable per indicator, else blink
// [R10] Combination disable gives link-only / duplex-only
// [R11] Activity select and pulsing enable stored bits
// [R12] Drive bit picks open-drain or push-pull
// [R13] Eight event enables in bits 15:8
// [R14] Eight event flags in bits 7:0, read-clear
// [R15] Control bit 14 inverts interrupt level
// [R16] Flags always record; enabled flags drive interrupt
// [R17] Timing derived by dividing the reference clock
`timescale 1ns/1ps
`default_nettype none
module pvl_regs
  import pvl_pkg::*;
#(
  parameter int TICK_CYC = PVL_TICK_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Register port from the management frame engine
  input  wire logic [4:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic [15:0]      reg_rdata,
  // Status from the transceiver core
  input  wire logic        link_1000_ok,
  input  wire logic        link_100_ok,
  input  wire logic        rx_err_evt,
  input  wire logic [7:0]  event_in,
  input  wire logic        link_lvl,
  input  wire logic        activity_evt,
  input  wire logic        duplex_lvl,
  input  wire logic        collision_evt,
  // Management data output pin
  input  wire logic        mdio_tx_bit,
  input  wire logic        mdio_tx_active,
  output logic             mdio_out,
  output logic             mdio_oe,
  // Indicator pins and function codes for the function decoder
  output logic             first_indicator,
  output logic             second_indicator,
  output logic [3:0]       first_indicator_func,
  output logic [3:0]       second_indicator_func,
  output logic             legacy_indicator_scheme,
  output logic             act_out_select,
  output logic             pulsing_enable,
  // Interrupt pin level
  output logic             irq_pin
);
  // Stored control fields
  logic [3:0]  sel_second_reg;  // Second indicator function
  logic [3:0]  sel_first_reg;   // First indicator function
  logic        act_sel_reg;     // Activity output select
  logic        pulse_en_reg;    // Pulsing enable
  logic [1:0]  rate_reg;        // Blink / stretch rate
  logic [1:0]  stretch_en_reg;  // Stretch enables
  logic [1:0]  comb_dis_reg;    // Combination disables
  logic        push_pull_reg;   // Drive type
  logic        legacy_reg;      // Legacy scheme select
  logic [7:0]  event_en_reg;    // Event enables
  logic [7:0]  event_flag_reg;  // Event flags
  logic        irq_inv_reg;     // Interrupt polarity invert
  logic [15:0] tally_reg;       // Receive error tally
  logic [15:0] tally_next;
  logic [7:0]  flag_next;
  logic [15:0] rdata_next;
  logic        irq_pending;
  logic [1:0]  ind_pins;

  pvl_ind_if ind_cfg ();

  // Single write strobe decode, used by several processes
  function automatic logic wr_hit(input logic [4:0] idx);
    wr_hit = reg_wr && (reg_addr == idx);
  endfunction

  // Single read strobe decode for read-clear effects
  function automatic logic rd_hit(input logic [4:0] idx);
    rd_hit = reg_rd && (reg_addr == idx);
  endfunction

  // Indicator function select fields
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sel_second_reg <= PVL_RST_SEL_SECOND;
      sel_first_reg  <= PVL_RST_SEL_FIRST;
    end else if (wr_hit(PVL_IDX_IND_SELECT)) begin
      sel_second_reg <= reg_wdata[PVL_POS_SEL_SECOND +: 4]; // [R3]
      sel_first_reg  <= reg_wdata[PVL_POS_SEL_FIRST +: 4];  // [R4]
    end
  end

  // Indicator behaviour fields
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      act_sel_reg    <= PVL_RST_ACT_SELECT;
      pulse_en_reg   <= PVL_RST_PULSE_EN;
      rate_reg       <= PVL_RST_RATE;
      stretch_en_reg <= PVL_RST_STRETCH_EN;
      comb_dis_reg   <= PVL_RST_COMB_DIS;
    end else if (wr_hit(PVL_IDX_IND_BEHAV)) begin
      act_sel_reg    <= reg_wdata[PVL_POS_ACT_SELECT];      // [R11]
      pulse_en_reg   <= reg_wdata[PVL_POS_PULSE_EN];        // [R11]
      rate_reg       <= reg_wdata[PVL_POS_RATE +: 2];       // [R8]
      stretch_en_reg <= reg_wdata[PVL_POS_STRETCH_EN +: 2]; // [R9]
      comb_dis_reg   <= reg_wdata[PVL_POS_COMB_DIS +: 2];   // [R10]
    end
  end

  // Output drive type
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      push_pull_reg <= PVL_RST_PUSH_PULL;
    end else if (wr_hit(PVL_IDX_OUT_DRIVE)) begin
      push_pull_reg <= reg_wdata[PVL_POS_PUSH_PULL]; // [R12]
    end
  end

  // Indicator scheme; software is expected to keep this at 1
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      legacy_reg <= PVL_RST_LEGACY;
    end else if (wr_hit(PVL_IDX_IND_SCHEME)) begin
      legacy_reg <= reg_wdata[PVL_POS_LEGACY]; // [R6] [R7]
    end
  end

  // Event enables
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      event_en_reg <= PVL_RST_EVENT_EN;
    end else if (wr_hit(PVL_IDX_EVENT)) begin
      event_en_reg <= reg_wdata[PVL_POS_EVENT_EN +: 8]; // [R13]
    end
  end

  // Interrupt polarity
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      irq_inv_reg <= PVL_RST_IRQ_INVERT;
    end else if (wr_hit(PVL_IDX_CONTROL)) begin
      irq_inv_reg <= reg_wdata[PVL_POS_IRQ_INVERT]; // [R15]
    end
  end

  // Flag update: a read clears, but an event in the same cycle survives
  always_comb begin
    flag_next = event_flag_reg;
    if (rd_hit(PVL_IDX_EVENT)) begin
      flag_next = 8'h00;                   // [R14]
    end
    flag_next = flag_next | event_in;      // [R16]
  end

  // Event flags, recorded regardless of enable
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      event_flag_reg <= PVL_RST_EVENT_FLAG;
    end else begin
      event_flag_reg <= flag_next; // [R14] [R16]
    end
  end

  // Tally update: read clears; an error in the read cycle counts as one
  always_comb begin
    tally_next = tally_reg;
    if (rd_hit(PVL_IDX_RXERR_TALLY)) begin
      tally_next = rx_err_evt ? 16'h0001 : PVL_RST_TALLY; // [R2]
    end else if (rx_err_evt && tally_reg != PVL_TALLY_MAX) begin
      tally_next = tally_reg + 16'h0001;                  // [R2]
    end
  end

  // Receive error tally
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tally_reg <= PVL_RST_TALLY;
    end else begin
      tally_reg <= tally_next;
    end
  end

  // Read data mux; unmapped indices and reserved bits read zero
  always_comb begin
    rdata_next = 16'h0000;
    unique case (reg_addr)
      PVL_IDX_LINK_HEALTH: begin
        rdata_next[PVL_POS_LINK_1000] = link_1000_ok; // [R1]
        rdata_next[PVL_POS_LINK_100]  = link_100_ok;  // [R1]
      end
      PVL_IDX_RXERR_TALLY: begin
        rdata_next = tally_reg;
      end
      PVL_IDX_IND_SELECT: begin
        rdata_next[PVL_POS_SEL_SECOND +: 4] = sel_second_reg;
        rdata_next[PVL_POS_SEL_FIRST +: 4]  = sel_first_reg;
      end
      PVL_IDX_IND_BEHAV: begin
        rdata_next[PVL_POS_ACT_SELECT]      = act_sel_reg;
        rdata_next[PVL_POS_PULSE_EN]        = pulse_en_reg;
        rdata_next[PVL_POS_RATE +: 2]       = rate_reg;
        rdata_next[PVL_POS_STRETCH_EN +: 2] = stretch_en_reg;
        rdata_next[PVL_POS_COMB_DIS +: 2]   = comb_dis_reg;
      end
      PVL_IDX_OUT_DRIVE: begin
        rdata_next[PVL_POS_PUSH_PULL] = push_pull_reg;
      end
      PVL_IDX_IND_SCHEME: begin
        rdata_next[PVL_POS_LEGACY] = legacy_reg;
      end
      PVL_IDX_EVENT: begin
        rdata_next[PVL_POS_EVENT_EN +: 8]   = event_en_reg;
        rdata_next[PVL_POS_EVENT_FLAG +: 8] = event_flag_reg;
      end
      PVL_IDX_CONTROL: begin
        rdata_next[PVL_POS_IRQ_INVERT] = irq_inv_reg;
      end
      default: begin
        rdata_next = 16'h0000;
      end
    endcase
  end

  // Read data is captured on the read strobe and held until the next read
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end

  // Interrupt: any enabled flag pending; idle level is high unless inverted
  assign irq_pending = |(event_flag_reg & event_en_reg); // [R16]
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      irq_pin <= 1'b1;
    end else begin
      irq_pin <= irq_inv_reg ? irq_pending : ~irq_pending; // [R15]
    end
  end

  // Management data output: open-drain only pulls low, push-pull drives both
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      mdio_out <= 1'b0;
      mdio_oe  <= 1'b0;
    end else if (push_pull_reg) begin
      mdio_out <= mdio_tx_bit;                      // [R12]
      mdio_oe  <= mdio_tx_active;                   // [R12]
    end else begin
      mdio_out <= 1'b0;                             // [R12]
      mdio_oe  <= mdio_tx_active & ~mdio_tx_bit;    // [R12]
    end
  end

  // Rate reaches the timing engine only in the extended scheme; stretch and combination enables pass always and are gated there
  assign ind_cfg.extended   = ~legacy_reg;                          // [R5]
  assign ind_cfg.rate       = legacy_reg ? PVL_RST_RATE : rate_reg; // [R5]
  assign ind_cfg.stretch_en = stretch_en_reg;
  assign ind_cfg.comb_dis   = comb_dis_reg;

  // Blink / stretch engine; first shows link, second shows duplex
  pvl_ind_timing #(
    .TICK_CYC (TICK_CYC)
  ) u_timing (
    .core_clk (core_clk),
    .nrst     (nrst),
    .base_lvl ({duplex_lvl, link_lvl}),
    .act_evt  ({collision_evt, activity_evt}),
    .cfg      (ind_cfg),
    .ind_out  (ind_pins)
  );

  assign first_indicator  = ind_pins[0];
  assign second_indicator = ind_pins[1];

  // Function codes go to the decoder only in the extended scheme
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      first_indicator_func  <= PVL_RST_SEL_FIRST;
      second_indicator_func <= PVL_RST_SEL_SECOND;
    end else if (!legacy_reg) begin
      first_indicator_func  <= sel_first_reg;  // [R4] [R5]
      second_indicator_func <= sel_second_reg; // [R3] [R5]
    end else begin
      first_indicator_func  <= PVL_RST_SEL_FIRST;
      second_indicator_func <= PVL_RST_SEL_SECOND;
    end
  end

  // Scheme and behaviour bits exported for the pin logic
  assign legacy_indicator_scheme = legacy_reg;
  assign act_out_select          = act_sel_reg & ~legacy_reg;  // [R5] [R11]
  assign pulsing_enable          = pulse_en_reg & ~legacy_reg; // [R5] [R11]
endmodule
`default_nettype wire

// ==== testbench/pvl_regs_monitor.sv ====
// Concurrent checks on the register bank ports
`timescale 1ns/1ps
`default_nettype none
module pvl_regs_monitor
  import pvl_pkg::*;
#(
  parameter int TICK_CYC = PVL_TICK_CYCLES
) (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic [4:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        link_1000_ok,
  input wire logic        link_100_ok,
  input wire logic        rx_err_evt,
  input wire logic [7:0]  event_in,
  input wire logic        mdio_tx_bit,
  input wire logic        mdio_tx_active,
  input wire logic        mdio_out,
  input wire logic        mdio_oe,
  input wire logic [3:0]  first_indicator_func,
  input wire logic [3:0]  second_indicator_func,
  input wire logic        legacy_indicator_scheme,
  input wire logic        irq_pin
);
  logic [15:0] rsv_m; // Bits that must read zero at the addressed index
  // Reserved and unmapped bits per index
  always_comb begin
    case (reg_addr)
      PVL_IDX_LINK_HEALTH:                 rsv_m = 16'hFFFC;
      PVL_IDX_RXERR_TALLY, PVL_IDX_EVENT:  rsv_m = 16'h0000;
      PVL_IDX_IND_SELECT:                  rsv_m = 16'hFF00;
      PVL_IDX_IND_BEHAV:                   rsv_m = 16'hA39C;
      PVL_IDX_OUT_DRIVE:                   rsv_m = 16'hFFFD;
      PVL_IDX_IND_SCHEME, PVL_IDX_CONTROL: rsv_m = 16'hBFFF;
      default:                             rsv_m = 16'hFFFF;
    endcase
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Read strobes and quiet cycles
  sequence tally_rd_s; reg_rd && reg_addr == PVL_IDX_RXERR_TALLY; endsequence
  sequence flag_rd_s; reg_rd && reg_addr == PVL_IDX_EVENT; endsequence
  sequence quiet_s; !reg_wr && !reg_rd && event_in == 8'h00; endsequence

  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  health_read_a: assert property (reg_rd && reg_addr == PVL_IDX_LINK_HEALTH
    |=> reg_rdata == {14'h0000, $past(link_1000_ok), $past(link_100_ok)})
    else $error("link health read wrong");
  reserved_zero_a: assert property (reg_rd |=> (reg_rdata & $past(rsv_m)) == 16'h0000)
    else $error("reserved bits not zero");
  tally_clear_a: assert property (tally_rd_s ##0 !rx_err_evt ##1 !rx_err_evt
    ##1 tally_rd_s |=> reg_rdata == 16'h0000)
    else $error("tally not cleared by read");
  flag_clear_a: assert property (flag_rd_s ##0 event_in == 8'h00 ##1 event_in == 8'h00
    ##1 flag_rd_s |=> reg_rdata[7:0] == 8'h00)
    else $error("flags not cleared by read");
  legacy_func_a: assert property (legacy_indicator_scheme [*3] |->
    first_indicator_func == PVL_RST_SEL_FIRST && second_indicator_func == PVL_RST_SEL_SECOND)
    else $error("function codes not forced in legacy scheme");
  mdio_low_a: assert property ($past(mdio_tx_active) && !$past(mdio_tx_bit)
    |-> mdio_oe && !mdio_out)
    else $error("data low not driven");
  mdio_window_a: assert property (mdio_oe |-> $past(mdio_tx_active))
    else $error("data driven outside window");
  irq_quiet_a: assert property (quiet_s [*3] |=> $stable(irq_pin))
    else $error("interrupt moved without cause");
endmodule
bind pvl_regs pvl_regs_monitor #(.TICK_CYC(TICK_CYC)) u_mon (
  .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_1000_ok(link_1000_ok),
  .link_100_ok(link_100_ok), .rx_err_evt(rx_err_evt), .event_in(event_in),
  .mdio_tx_bit(mdio_tx_bit), .mdio_tx_active(mdio_tx_active), .mdio_out(mdio_out),
  .mdio_oe(mdio_oe), .first_indicator_func(first_indicator_func),
  .second_indicator_func(second_indicator_func),
  .legacy_indicator_scheme(legacy_indicator_scheme), .irq_pin(irq_pin));
`default_nettype wire

// ==== testbench/pvl_mgmt_model.sv ====
// Management controller model issuing register accesses
`timescale 1ns/1ps
`default_nettype none
module pvl_mgmt_model (
  input  wire logic   core_clk,
  output logic [4:0]  reg_addr,
  output logic        reg_wr,
  output logic        reg_rd,
  output logic [15:0] reg_wdata
);
  // Idle bus at time zero
  initial begin
    reg_addr  = 5'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 16'h0000;
  end
  // One access: strobe raised after an edge, dropped after the taking edge
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    #5;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = w;
    reg_rd    = !w;
    @(posedge core_clk);
    #5;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = ~d; // Released data does not keep its last value
  endtask
endmodule
`default_nettype wire

// ==== testbench/pvl_regs_tb.sv ====
// Self-checking bench for the vendor register bank
`timescale 1ns/1ps
`default_nettype none
module pvl_regs_tb;
  import pvl_pkg::*;
  logic        core_clk, nrst, link_1000_ok, link_100_ok, rx_err_evt, rd_q;
  logic        link_lvl, activity_evt, duplex_lvl, collision_evt, mdio_tx_bit;
  logic        mdio_tx_active, mdio_out, mdio_oe, first_indicator, second_indicator;
  logic        legacy_indicator_scheme, act_out_select, pulsing_enable, irq_pin;
  logic [7:0]  event_in;
  logic [4:0]  reg_addr;
  logic        reg_wr, reg_rd;
  logic [15:0] reg_wdata, reg_rdata, exp_val, wd;
  logic [3:0]  first_indicator_func, second_indicator_func;
  logic [15:0] exp_q[$];                 // Expected read results in issue order
  logic [4:0]  idx[7] = '{5'h13, 5'h14, 5'h16, 5'h17, 5'h19, 5'h1F, 5'h1B};
  logic [15:0] msk[7] = '{16'h0000, 16'h0000, 16'h00FF, 16'h5C63, 16'h0002, 16'h4000, 16'hFF00};
  logic [15:0] mdx[4] = '{16'h0002, 16'h0000, 16'h0002, 16'h0003};
  int          n_errors, checks_done, seed, k;

  pvl_regs #(.TICK_CYC(4)) dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .link_1000_ok(link_1000_ok), .link_100_ok(link_100_ok), .rx_err_evt(rx_err_evt),
    .event_in(event_in), .link_lvl(link_lvl), .activity_evt(activity_evt),
    .duplex_lvl(duplex_lvl), .collision_evt(collision_evt), .mdio_tx_bit(mdio_tx_bit),
    .mdio_tx_active(mdio_tx_active), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .first_indicator(first_indicator), .second_indicator(second_indicator),
    .first_indicator_func(first_indicator_func), .second_indicator_func(second_indicator_func),
    .legacy_indicator_scheme(legacy_indicator_scheme), .act_out_select(act_out_select),
    .pulsing_enable(pulsing_enable), .irq_pin(irq_pin));
  pvl_mgmt_model u_mgmt (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata));

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Read with its expectation queued for the watcher
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    u_mgmt.acc(1'b0, a, 16'h0000);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    u_mgmt.acc(1'b1, a, d);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #5;
  endtask
  task automatic give_verdict();
    if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Clock at 20 MHz
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Read data lands on the taking edge and is checked one cycle later
  always @(posedge core_clk) rd_q <= reg_rd;
  always @(posedge core_clk) begin
    if (rd_q === 1'b1) begin
      #2;
      exp_val = exp_q.pop_front();
      check(reg_rdata, exp_val, "reg_rdata");
    end
  end
  // Watchdog against a hang
  initial begin
    repeat (80000) @(posedge core_clk);
    n_errors++;
    give_verdict();
  end

  // Main sequence
  initial begin
    seed = 32'h94CD;
    {n_errors, checks_done} = '0;
    {nrst, link_1000_ok, link_100_ok, rx_err_evt, link_lvl, activity_evt} = '0;
    {duplex_lvl, collision_evt, mdio_tx_bit, mdio_tx_active, event_in} = '0;
    repeat (16) @(posedge core_clk);
    #5;
    nrst = 1'b1;
    rd(PVL_IDX_IND_SELECT, 16'h0021);
    rd(PVL_IDX_IND_BEHAV, 16'h1000);
    rd(PVL_IDX_IND_SCHEME, 16'h4000);
    rd(PVL_IDX_RXERR_TALLY, PVL_RST_TALLY);
    check({15'h0000, irq_pin}, 16'h0001, "irq_pin");
    wd = {13'h0000, legacy_indicator_scheme, act_out_select, pulsing_enable};
    check(wd, 16'h0004, "scheme outs");
    // Random writes read back through the field masks
    for (k = 0; k < 7; k++) begin
      wd = $random(seed);
      wr(idx[k], wd);
      rd(idx[k], wd & msk[k]);
    end
    // Undo the random settings that later scenarios rely on
    wr(PVL_IDX_EVENT, 16'h0000);
    wr(PVL_IDX_CONTROL, 16'h0000);
    wr(PVL_IDX_OUT_DRIVE, 16'h0000);
    // Live link levels
    link_1000_ok = 1'b1;
    cyc(2);
    rd(PVL_IDX_LINK_HEALTH, 16'h0002);
    {link_1000_ok, link_100_ok} = 2'b01;
    cyc(2);
    rd(PVL_IDX_LINK_HEALTH, 16'h0001);
    // Error tally: random count, then saturation
    k = {$random(seed)} % 16 + 1;
    rx_err_evt = 1'b1;
    cyc(k);
    rx_err_evt = 1'b0;
    rd(PVL_IDX_RXERR_TALLY, k[15:0]);
    rd(PVL_IDX_RXERR_TALLY, 16'h0000);
    rx_err_evt = 1'b1;
    cyc(65540);
    rx_err_evt = 1'b0;
    rd(PVL_IDX_RXERR_TALLY, PVL_TALLY_MAX);
    // Extended scheme: codes, then blink and combination at the fastest rate
    wr(PVL_IDX_IND_SELECT, 16'h0073);
    wr(PVL_IDX_IND_SCHEME, 16'h0000);
    cyc(3);
    check({8'h00, second_indicator_func, first_indicator_func}, 16'h0073, "func");
    {link_lvl, duplex_lvl, activity_evt, collision_evt} = 4'hF;
    // Stretch, then blink, at the fastest rate, then the legacy scheme ignores both
    for (int m = 0; m < 3; m++) begin
      if (m < 2) begin
        wr(PVL_IDX_IND_BEHAV, m ? 16'h1C01 : 16'h1C41);
      end else begin
        wr(PVL_IDX_IND_SCHEME, 16'h4000);
      end
      cyc(20);
      k = 0;
      repeat (64) begin
        cyc(1);
        k += first_indicator + second_indicator;
      end
      check(k[15:0], (m == 1) ? 16'h0060 : 16'h0040, "lit cycles");
      wd = {13'h0000, legacy_indicator_scheme, act_out_select, pulsing_enable};
      check(wd, (m == 2) ? 16'h0004 : 16'h0001, "scheme outs");
    end
    check({8'h00, second_indicator_func, first_indicator_func}, 16'h0021, "func");
    // Data pin drive: open-drain then push-pull
    mdio_tx_active = 1'b1;
    for (k = 0; k < 4; k++) begin
      if (k == 2) wr(PVL_IDX_OUT_DRIVE, 16'h0002);
      mdio_tx_bit = k[0];
      cyc(2);
      check({14'h0000, mdio_oe, mdio_out}, mdx[k], "mdio");
    end
    mdio_tx_active = 1'b0;
    // Events recorded while disabled, then enabled, then polarity inverted
    wd = $random(seed) | 16'h0001;
    event_in = wd[7:0];
    cyc(1);
    event_in = 8'h00;
    cyc(2);
    check({15'h0000, irq_pin}, 16'h0001, "irq_pin");
    rd(PVL_IDX_EVENT, {8'h00, wd[7:0]});
    rd(PVL_IDX_EVENT, 16'h0000);
    wr(PVL_IDX_EVENT, 16'h0100);
    event_in = 8'h01;
    cyc(1);
    event_in = 8'h00;
    cyc(2);
    check({15'h0000, irq_pin}, 16'h0000, "irq_pin");
    wr(PVL_IDX_CONTROL, 16'h4000);
    cyc(2);
    check({15'h0000, irq_pin}, 16'h0001, "irq_pin");
    rd(PVL_IDX_EVENT, 16'h0101);
    cyc(3);
    check({15'h0000, irq_pin}, 16'h0000, "irq_pin");
    give_verdict();
  end
endmodule
`default_nettype wire
